// [rtl/trc_pkg.sv]
// Package: register map, field layout and carrier types for tap/rate config
package trc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h03;
    localparam logic [7:0] ADDR_RATE = 8'h08;
    localparam logic [7:0] ADDR_TAPCTL = 8'h09;
    localparam logic [7:0] ADDR_AXIS_X = 8'h0a;
    localparam logic [7:0] ADDR_AXIS_Z = 8'h0c;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RATE_LSB = 0;
    localparam int SWAP_LSB = 4;
    localparam int LATCH_BIT = 7;
    localparam int BANK_BIT = 6;
    localparam int MASTER_BIT = 7;
    localparam int QUIET_LSB = 4;
    // ----------------------------------------------------------------
    // Rate codes and step in quarter-hertz units
    // ----------------------------------------------------------------
    localparam logic [3:0] RATE_HALVE_LAST = 4'h7;
    localparam logic [3:0] RATE_FAST_FIRST = 4'h8;
    localparam logic [3:0] RATE_FAST_LAST = 4'ha;
    localparam logic [10:0] QHZ_AT_32HZ = 11'h080;
    localparam logic [10:0] QHZ_AT_64HZ = 11'h100;
    localparam int QUARTERS_PER_HZ = 4;
    localparam int CLK_HZ_DEFAULT = 250_000_000;
    localparam logic [3:0] RUN_MAX = 4'hf;
    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic neg;
        logic [7:0] mag;
    } trc_axis_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } trc_req_t;
endpackage : trc_pkg

// [rtl/trc_tap_rate_config.sv]
// Module: tap and sample rate configuration with per-axis tap qualifier
// Notes on behaviour
// - Sample tick rate comes from the rate field of the rate register.
// - Codes 0-7 give 32..0.25 Hz, 8-10 give 64..256 Hz; 11-15 reserved.
// - Polarity-swap bit per axis reports positive taps as negative, and back.
// - Latch bit clear: every enabled tap is recorded and accumulates.
// - Latch bit set: first tap held, others ignored until status read.
// - Six enables gate positive/negative taps per axis, bits 0 to 5.
// - Master enable clear disables all tap detection.
// - Bank bit clear: 0x0a-0x0c reach duration and quiet settings.
// - Bank bit set: 0x0a-0x0c reach threshold settings.
// - Events over threshold longer than duration samples are rejected if duration is below 15.
// - After a tap, quiet samples are ignored, then detection rearms.
// - Unsigned threshold is the minimum magnitude for a tap.
`timescale 1ns/1ns
`default_nettype none
module trc_tap_rate_config #(
    parameter int CLK_HZ = trc_pkg::CLK_HZ_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst,
    input wire trc_pkg::trc_req_t req,
    input wire trc_pkg::trc_axis_t [2:0] accel,
    output logic [7:0] reg_rdata,
    output logic sample_tick,
    output logic [3:0] output_sample_frequency,
    output logic [5:0] tap_flags
);
    import trc_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic is_axis_addr(input logic [7:0] a);
        is_axis_addr = (a >= ADDR_AXIS_X) && (a <= ADDR_AXIS_Z);
    endfunction : is_axis_addr

    function automatic logic [1:0] axis_of(input logic [7:0] a);
        logic [7:0] d;
        d = a - ADDR_AXIS_X;
        axis_of = d[1:0];
    endfunction : axis_of

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [7:0] rate_cfg_r;
    logic [7:0] tap_ctl_r;
    logic [7:0] dur_quiet_r [3];
    logic [7:0] thresh_r [3];
    logic [5:0] tap_flags_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rate_cfg_r <= RESET_BYTE;
            tap_ctl_r <= RESET_BYTE;
        end else if (req.wr) begin
            if (req.addr == ADDR_RATE) begin
                rate_cfg_r <= req.wdata;
            end else if (req.addr == ADDR_TAPCTL) begin
                tap_ctl_r <= req.wdata;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_bank
            always_ff @(posedge mclk) begin
                if (rst) begin
                    dur_quiet_r[g] <= RESET_BYTE;
                    thresh_r[g] <= RESET_BYTE;
                end else if (req.wr && is_axis_addr(req.addr)
                             && axis_of(req.addr) == 2'(g)) begin
                    if (tap_ctl_r[BANK_BIT]) begin
                        thresh_r[g] <= req.wdata;
                    end else begin
                        dur_quiet_r[g] <= req.wdata;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= RESET_BYTE;
        end else if (req.rd) begin
            if (req.addr == ADDR_STATUS) begin
                reg_rdata <= {2'h0, tap_flags_r};
            end else if (req.addr == ADDR_RATE) begin
                reg_rdata <= rate_cfg_r;
            end else if (req.addr == ADDR_TAPCTL) begin
                reg_rdata <= tap_ctl_r;
            end else if (is_axis_addr(req.addr)) begin
                reg_rdata <= tap_ctl_r[BANK_BIT]
                    ? thresh_r[axis_of(req.addr)]
                    : dur_quiet_r[axis_of(req.addr)];
            end else begin
                reg_rdata <= RESET_BYTE;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sample rate generator
    // ----------------------------------------------------------------
    // Phase accumulator in quarter-hertz steps: exact for every code,
    // no rounding drift even at 0.25 Hz.
    localparam logic [31:0] ACC_WRAP = 32'(CLK_HZ * QUARTERS_PER_HZ);
    logic [3:0] rate_code;
    logic [10:0] step_qhz;
    logic [31:0] phase_r;
    logic [32:0] phase_sum;

    assign rate_code = rate_cfg_r[RATE_LSB +: 4];

    always_comb begin
        step_qhz = 11'h000;
        if (rate_code <= RATE_HALVE_LAST) begin
            step_qhz = QHZ_AT_32HZ >> rate_code;
        end else if (rate_code <= RATE_FAST_LAST) begin
            step_qhz = QHZ_AT_64HZ << (rate_code - RATE_FAST_FIRST);
        end
    end

    assign phase_sum = {1'b0, phase_r} + {22'h0, step_qhz};

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_r <= 32'h0;
            sample_tick <= 1'b0;
        end else if (phase_sum >= {1'b0, ACC_WRAP}) begin
            phase_r <= 32'(phase_sum - {1'b0, ACC_WRAP});
            sample_tick <= 1'b1;
        end else begin
            phase_r <= phase_sum[31:0];
            sample_tick <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            output_sample_frequency <= 4'h0;
        end else begin
            output_sample_frequency <= rate_code;
        end
    end

    // ----------------------------------------------------------------
    // Per-axis tap qualifier, stepped once per sample tick
    // ----------------------------------------------------------------
    logic [5:0] hit;

    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic [3:0] run_r;
            logic [3:0] quiet_r;
            logic neg_r;
            logic over;
            assign over = accel[g].mag >= thresh_r[g];

            always_ff @(posedge mclk) begin
                if (rst) begin
                    run_r <= 4'h0;
                    quiet_r <= 4'h0;
                    neg_r <= 1'b0;
                    hit[2*g +: 2] <= 2'b00;
                end else begin
                    hit[2*g +: 2] <= 2'b00;
                    if (sample_tick) begin
                        if (quiet_r != 4'h0) begin
                            quiet_r <= quiet_r - 4'h1;
                            run_r <= 4'h0;
                        end else if (over) begin
                            run_r <= (run_r == RUN_MAX) ? RUN_MAX
                                                        : run_r + 4'h1;
                            neg_r <= accel[g].neg;
                        end else begin
                            run_r <= 4'h0;
                            // Too-long events count only at duration 15, where run_r saturates
                            if (run_r != 4'h0
                                && run_r <= dur_quiet_r[g][3:0]) begin
                                quiet_r <= dur_quiet_r[g][QUIET_LSB +: 4];
                                if (neg_r ^ rate_cfg_r[SWAP_LSB + g]) begin
                                    hit[2*g +: 2] <= 2'b10;
                                end else begin
                                    hit[2*g +: 2] <= 2'b01;
                                end
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Tap flags: set wins over read-clear
    // ----------------------------------------------------------------
    logic [5:0] accepted;
    logic status_read;
    logic held;

    assign status_read = req.rd && (req.addr == ADDR_STATUS);
    assign held = rate_cfg_r[LATCH_BIT] && (tap_flags_r != 6'h0)
                  && !status_read;
    assign accepted = (held || !tap_ctl_r[MASTER_BIT]) ? 6'h0
                      : (hit & tap_ctl_r[5:0]);

    always_ff @(posedge mclk) begin
        if (rst) begin
            tap_flags_r <= 6'h0;
        end else if (status_read) begin
            tap_flags_r <= accepted;
        end else begin
            tap_flags_r <= tap_flags_r | accepted;
        end
    end

    assign tap_flags = tap_flags_r;
endmodule : trc_tap_rate_config
`default_nettype wire

// [testbench/tb_tap_and_rate_config.sv]
// Testbench: register, rate and tap scenarios against a bench model
`timescale 1ns/1ns
`default_nettype none
module tb_tap_and_rate_config;
    import trc_pkg::*;
    // Small clock keeps the 0.25 Hz period near eight thousand cycles
    localparam int CLK = 2048;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    trc_req_t req;
    trc_axis_t [2:0] accel = '0;
    logic [7:0] reg_rdata;
    logic [7:0] q;
    logic sample_tick;
    logic [3:0] output_sample_frequency;
    logic [5:0] tap_flags;
    logic [31:0] lfsr_r = 32'h2ce9d753;
    int mismatches = 0;
    int checks_done = 0;
    int regs[2][16];
    int flags = 0;
    int n;
    trc_tap_rate_config #(.CLK_HZ(CLK)) DUT (.mclk(mclk), .rst(rst),
        .req(req), .accel(accel), .reg_rdata(reg_rdata),
        .sample_tick(sample_tick), .tap_flags(tap_flags),
        .output_sample_frequency(output_sample_frequency));
    trc_host host (.mclk(mclk), .req(req), .reg_rdata(reg_rdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic tick(input int lim, input bit must = 1'b1);
        n = 0;
        do @(posedge mclk) n++; while (sample_tick !== 1'b1 && n < lim);
        if (must && sample_tick !== 1'b1) begin
            mismatches++;
            wrap_up();
        end
    endtask : tick
    task automatic wr(input logic [7:0] a, d);
        host.acc(1'b1, a, d, q);
        if (a >= ADDR_RATE && a <= ADDR_AXIS_Z)
            regs[a >= ADDR_AXIS_X ? regs[0][9][6] : 0][a] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int e;
        e = a == ADDR_STATUS ? flags : 0;
        if (a >= ADDR_RATE && a <= ADDR_AXIS_Z)
            e = regs[a >= ADDR_AXIS_X ? regs[0][9][6] : 0][a];
        host.acc(1'b0, a, 8'h00, q);
        if (a == ADDR_STATUS)
            flags = 0;
        chk($sformatf("reg %h", a), e, q);
    endtask : rd
    // Event: len samples over or under threshold, then quiet time
    task automatic ev(input int ax, neg, len, input bit big);
        int b;
        lfsr_r = lfsr(lfsr_r);
        tick(40);
        accel[ax] <= '{neg[0], big ? 8'h40 + lfsr_r[6:0] : 8'h3f - lfsr_r[5:0]};
        repeat (len) tick(40);
        accel[ax] <= '0;
        b = 2 * ax + (neg ^ regs[0][8][4 + ax]);
        if (big && len <= (regs[0][10 + ax] & 15) && regs[0][9][7]
            && regs[0][9][b] && !(regs[0][8][7] && flags != 0))
            flags |= 1 << b;
        repeat (4) tick(40);
        chk("tap flags", flags, tap_flags);
    endtask : ev
    initial begin
        forever #2 mclk = ~mclk;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 3; a < 14; a++) rd(a);
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_RATE, c[7:0]);
            repeat (2) @(posedge mclk);
            chk("rate code", c, output_sample_frequency);
            if (c > 10) begin
                tick(300, 1'b0);
                chk("idle cycles", 300, n);
            end else begin
                tick(20000);
                tick(20000);
                chk("period", 4 * CLK / (c < 8 ? 128 >> c : 256 << (c - 8)), n);
            end
        end
        wr(ADDR_RATE, 8'h0a);
        wr(ADDR_TAPCTL, 8'h7f);
        for (int a = 10; a < 13; a++) wr(a, 8'h40);
        wr(ADDR_TAPCTL, 8'h3f);
        for (int a = 10; a < 13; a++) wr(a, 8'h23);
        for (int a = 3; a < 14; a++) rd(a);
        ev(0, 0, 2, 1'b1);
        wr(ADDR_TAPCTL, 8'hbf);
        ev(0, 0, 2, 1'b1);
        ev(1, 1, 3, 1'b1);
        ev(2, 0, 4, 1'b1);
        ev(2, 0, 1, 1'b0);
        rd(ADDR_STATUS);
        wr(ADDR_RATE, 8'h1a);
        ev(0, 0, 1, 1'b1);
        wr(ADDR_TAPCTL, 8'haf);
        ev(2, 0, 2, 1'b1);
        wr(ADDR_RATE, 8'h8a);
        rd(ADDR_STATUS);
        ev(1, 0, 1, 1'b1);
        ev(2, 1, 1, 1'b1);
        rd(ADDR_STATUS);
        ev(2, 1, 1, 1'b1);
        wr(ADDR_TAPCTL, 8'h40);
        for (int a = 10; a < 13; a++) rd(a);
        wrap_up();
    end
endmodule : tb_tap_and_rate_config
bind trc_tap_rate_config trc_tap_rate_config_properties u_props (.mclk,
    .rst, .req, .accel, .reg_rdata, .sample_tick, .output_sample_frequency,
    .tap_flags);
`default_nettype wire

// [testbench/trc_host.sv]
// Host model: byte accesses over the strobe register bus
`timescale 1ns/1ns
`default_nettype none
module trc_host (
    input wire logic mclk,
    output var trc_pkg::trc_req_t req,
    input wire logic [7:0] reg_rdata
);
    import trc_pkg::*;
    initial req = '0;
    // Released bus shows inverted lines, so stale values never match
    task automatic acc(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q);
        @(posedge mclk) req <= '{w, !w, a, d};
        @(posedge mclk) req <= '{1'b0, 1'b0, ~a, ~d};
        @(posedge mclk) q = reg_rdata;
    endtask : acc
endmodule : trc_host
`default_nettype wire

// [testbench/trc_tap_rate_config_properties.sv]
// Checker: port-level properties of the tap and rate configuration
`timescale 1ns/1ns
`default_nettype none
module trc_tap_rate_config_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire trc_pkg::trc_req_t req,
    input wire trc_pkg::trc_axis_t [2:0] accel,
    input wire logic [7:0] reg_rdata,
    input wire logic sample_tick,
    input wire logic [3:0] output_sample_frequency,
    input wire logic [5:0] tap_flags
);
    import trc_pkg::*;
    logic [7:0] rate_r;
    logic [7:0] ctl_r;
    logic [1:0] age_r;
    logic rd3;
    assign rd3 = req.rd && req.addr == ADDR_STATUS;
    always_ff @(posedge mclk) begin
        if (rst) begin
            rate_r <= RESET_BYTE;
            ctl_r <= RESET_BYTE;
        end else if (req.wr && req.addr == ADDR_RATE) begin
            rate_r <= req.wdata;
        end else if (req.wr && req.addr == ADDR_TAPCTL) begin
            ctl_r <= req.wdata;
        end
    end
    // Age since a rate or tap control write; tap pipeline needs three cycles to settle
    always_ff @(posedge mclk) begin
        if (rst || (req.wr && req.addr[7:1] == 7'h04)) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_rate_follows: assert property (age_r == 2'h3
        |-> output_sample_frequency == rate_r[3:0]) else $error("rate code");
    chk_rate_readback: assert property (req.rd && !req.wr
        && req.addr == ADDR_RATE |=> reg_rdata == rate_r) else $error("rate rd");
    chk_reserved_silent: assert property (age_r == 2'h3
        && rate_r[3:0] > RATE_FAST_LAST |-> !sample_tick) else $error("tick");
    chk_ctl_readback: assert property (req.rd && !req.wr
        && req.addr == ADDR_TAPCTL |=> reg_rdata == ctl_r) else $error("ctl rd");
    chk_master_off: assert property (age_r == 2'h3 && !ctl_r[MASTER_BIT]
        |-> (tap_flags & ~$past(tap_flags)) == 6'h00) else $error("master");
    chk_enable_gate: assert property (age_r == 2'h3
        |-> (tap_flags & ~$past(tap_flags) & ~ctl_r[5:0]) == 6'h00)
        else $error("enable");
    chk_flags_sticky: assert property (!$past(rd3) && !$past(rst)
        |-> ($past(tap_flags) & ~tap_flags) == 6'h00) else $error("sticky");
    chk_latch_hold: assert property (age_r == 2'h3 && rate_r[LATCH_BIT]
        && $past(tap_flags) != 6'h00 && !$past(rd3)
        |-> tap_flags == $past(tap_flags)) else $error("latch");
    chk_status_read: assert property (rd3
        |=> reg_rdata[5:0] == $past(tap_flags)) else $error("status");
    cover property (sample_tick);
    cover property (rd3 && tap_flags != 6'h00);
    cover property (rate_r[LATCH_BIT] && tap_flags != 6'h00);
endmodule : trc_tap_rate_config_properties
`default_nettype wire
